// file: design/asf_axil_slave.sv
/*
 * AXI4-Lite slave front end: one write and one read under way at a time.
 * Assumes the register file answers rd_data and error flags combinationally.
 */
`timescale 1ns/1ps
`default_nettype none
module asf_axil_slave (
	// Clock and reset
	input  wire logic                           i_mclk,
	input  wire logic                           i_rst_n,
	// AXI4-Lite
	input  wire logic [asf_pkg::ASF_ADDR_W-1:0] i_awaddr,
	input  wire logic                           i_awvalid,
	output logic                                o_awready,
	input  wire logic [asf_pkg::ASF_DATA_W-1:0] i_wdata,
	input  wire logic [3:0]                     i_wstrb,
	input  wire logic                           i_wvalid,
	output logic                                o_wready,
	output logic [1:0]                          o_bresp,
	output logic                                o_bvalid,
	input  wire logic                           i_bready,
	input  wire logic [asf_pkg::ASF_ADDR_W-1:0] i_araddr,
	input  wire logic                           i_arvalid,
	output logic                                o_arready,
	output logic [asf_pkg::ASF_DATA_W-1:0]      o_rdata,
	output logic [1:0]                          o_rresp,
	output logic                                o_rvalid,
	input  wire logic                           i_rready,
	// Register file side
	output logic                                o_wr_req,
	output logic [asf_pkg::ASF_ADDR_W-1:0]      o_wr_addr,
	output logic [asf_pkg::ASF_DATA_W-1:0]      o_wr_data,
	output logic [3:0]                          o_wr_strb,
	input  wire logic                           i_wr_err,
	output logic                                o_rd_req,
	output logic [asf_pkg::ASF_ADDR_W-1:0]      o_rd_addr,
	input  wire logic [asf_pkg::ASF_DATA_W-1:0] i_rd_data,
	input  wire logic                           i_rd_err
);
	import asf_pkg::*;

	typedef struct packed {
		asf_state_t                wst;
		logic                      aw_have;
		logic                      w_have;
		logic [ASF_ADDR_W-1:0]     waddr;
		logic [ASF_DATA_W-1:0]     wdata;
		logic [3:0]                wstrb;
		logic                      awready;
		logic                      wready;
		logic                      bvalid;
		logic [1:0]                bresp;
		asf_state_t                rst;
		logic [ASF_ADDR_W-1:0]     raddr;
		logic                      arready;
		logic                      rvalid;
		logic [ASF_DATA_W-1:0]     rdata;
		logic [1:0]                rresp;
	} asf_axs_t;

	localparam asf_axs_t ASF_AXS_RST = '{
		wst: ASF_S_IDLE, aw_have: 1'b0, w_have: 1'b0, waddr: '0, wdata: '0,
		wstrb: 4'h0, awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: ASF_RESP_OKAY,
		rst: ASF_S_IDLE, raddr: '0, arready: 1'b1, rvalid: 1'b0, rdata: '0,
		rresp: ASF_RESP_OKAY};

	asf_axs_t r;
	asf_axs_t next_r;

	// Address and data may arrive in either order; the write fires once both are held.
	assign o_wr_req  = (r.wst == ASF_S_IDLE) && r.aw_have && r.w_have;
	assign o_wr_addr = r.waddr;
	assign o_wr_data = r.wdata;
	assign o_wr_strb = r.wstrb;
	assign o_rd_req  = (r.rst == ASF_S_BUSY);
	assign o_rd_addr = r.raddr;

	always_comb begin
		next_r = r;
		if (i_awvalid && r.awready) begin
			next_r.aw_have = 1'b1;
			next_r.waddr   = i_awaddr;
			next_r.awready = 1'b0;
		end
		if (i_wvalid && r.wready) begin
			next_r.w_have = 1'b1;
			next_r.wdata  = i_wdata;
			next_r.wstrb  = i_wstrb;
			next_r.wready = 1'b0;
		end
		case (r.wst)
			ASF_S_IDLE: begin
				if (o_wr_req) begin
					next_r.wst     = ASF_S_RESP;
					next_r.aw_have = 1'b0;
					next_r.w_have  = 1'b0;
					next_r.bvalid  = 1'b1;
					next_r.bresp   = i_wr_err ? ASF_RESP_SLVERR : ASF_RESP_OKAY;
				end
			end
			ASF_S_RESP: begin
				if (i_bready) begin
					next_r.wst     = ASF_S_IDLE;
					next_r.bvalid  = 1'b0;
					next_r.awready = 1'b1;
					next_r.wready  = 1'b1;
				end
			end
			default: begin
				next_r.wst = ASF_S_IDLE;
			end
		endcase
		case (r.rst)
			ASF_S_IDLE: begin
				if (i_arvalid && r.arready) begin
					next_r.rst     = ASF_S_BUSY;
					next_r.raddr   = i_araddr;
					next_r.arready = 1'b0;
				end
			end
			ASF_S_BUSY: begin
				next_r.rst    = ASF_S_RESP;
				next_r.rvalid = 1'b1;
				next_r.rdata  = i_rd_data;
				next_r.rresp  = i_rd_err ? ASF_RESP_SLVERR : ASF_RESP_OKAY;
			end
			ASF_S_RESP: begin
				if (i_rready) begin
					next_r.rst     = ASF_S_IDLE;
					next_r.rvalid  = 1'b0;
					next_r.arready = 1'b1;
				end
			end
			default: begin
				next_r.rst = ASF_S_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r <= ASF_AXS_RST;
		end else begin
			r <= next_r;
		end
	end

	assign o_awready = r.awready;
	assign o_wready  = r.wready;
	assign o_bvalid  = r.bvalid;
	assign o_bresp   = r.bresp;
	assign o_arready = r.arready;
	assign o_rvalid  = r.rvalid;
	assign o_rdata   = r.rdata;
	assign o_rresp   = r.rresp;
endmodule
`default_nettype wire

// file: design/asf_clamp.sv
/*
 * Range clamp for a freshly converted result.
 * Assumes the converter never flags overrange and underrange at once;
 * if it does, overrange wins.
 */
`timescale 1ns/1ps
`default_nettype none
module asf_clamp (
	// Raw result
	input  wire logic [asf_pkg::ASF_RES_W-1:0] i_raw,
	input  wire logic                          i_over,
	input  wire logic                          i_under,
	// Clamped result
	output logic      [asf_pkg::ASF_RES_W-1:0] o_result,
	output logic                               o_range_err
);
	import asf_pkg::*;

	always_comb begin
		o_range_err = i_over | i_under;
		if (i_over) begin
			o_result = ASF_RES_FULL;
		end else if (i_under) begin
			o_result = ASF_RES_EMPTY;
		end else begin
			o_result = i_raw;
		end
	end
endmodule
`default_nettype wire

// file: design/asf_status_top.sv
/*
 * Converter status register with data register, interface mode control,
 * interrupt status and mask, and the ready indication on the serial output pin.
 * Assumes conversion, checksum and register image inputs are synchronous
 * one-clock pulses or levels from the surrounding converter logic.
 */
`timescale 1ns/1ps
`default_nettype none
module asf_status_top (
	// Clock and reset
	input  wire logic                           i_mclk,
	input  wire logic                           i_rst_n,
	// AXI4-Lite register bus
	input  wire logic [asf_pkg::ASF_ADDR_W-1:0] i_awaddr,
	input  wire logic                           i_awvalid,
	output logic                                o_awready,
	input  wire logic [asf_pkg::ASF_DATA_W-1:0] i_wdata,
	input  wire logic [3:0]                     i_wstrb,
	input  wire logic                           i_wvalid,
	output logic                                o_wready,
	output logic [1:0]                          o_bresp,
	output logic                                o_bvalid,
	input  wire logic                           i_bready,
	input  wire logic [asf_pkg::ASF_ADDR_W-1:0] i_araddr,
	input  wire logic                           i_arvalid,
	output logic                                o_arready,
	output logic [asf_pkg::ASF_DATA_W-1:0]      o_rdata,
	output logic [1:0]                          o_rresp,
	output logic                                o_rvalid,
	input  wire logic                           i_rready,
	// Conversion engine
	input  wire logic                           i_result_valid,
	input  wire logic [asf_pkg::ASF_RES_W-1:0]  i_result,
	input  wire logic                           i_overrange,
	input  wire logic                           i_underrange,
	input  wire logic [asf_pkg::ASF_CHAN_W-1:0] i_result_chan,
	input  wire logic                           i_cal_mode,
	input  wire logic                           i_cal_done,
	// Serial interface events
	input  wire logic                           i_crc_wr_fail,
	input  wire logic [asf_pkg::ASF_DATA_W-1:0] i_reg_image,
	input  wire logic                           i_cs_n,
	input  wire logic                           i_reg_read_busy,
	// Serial output pin
	output logic                                o_dout_rdy,
	output logic                                o_dout_rdy_oe,
	// Interrupt
	output logic                                o_irq
);
	import asf_pkg::*;

	typedef struct packed {
		logic                  rdy;
		logic                  range_err;
		logic                  crc_err;
		logic                  reg_err;
		logic [ASF_CHAN_W-1:0] chan;
		logic [ASF_RES_W-1:0]  result;
		logic                  append;
		logic                  check_en;
		logic [ASF_DATA_W-1:0] check_ref;
		logic [ASF_IRQ_W-1:0]  irq_stat;
		logic [ASF_IRQ_W-1:0]  irq_mask;
		logic                  irq;
		logic                  dout;
		logic                  dout_oe;
	} asf_regs_t;

	localparam asf_regs_t ASF_REGS_RST = '{
		rdy: ASF_STATUS_RST[ASF_BIT_RDY], range_err: ASF_STATUS_RST[ASF_BIT_RANGE],
		crc_err: ASF_STATUS_RST[ASF_BIT_CRC], reg_err: ASF_STATUS_RST[ASF_BIT_REG],
		chan: ASF_STATUS_RST[ASF_CHAN_W-1:0], result: '0, append: 1'b0,
		check_en: 1'b0, check_ref: '0, irq_stat: '0, irq_mask: '0, irq: 1'b0,
		dout: 1'b0, dout_oe: 1'b0};

	asf_regs_t r;
	asf_regs_t next_r;

	logic                  wr_req;
	logic [ASF_ADDR_W-1:0] wr_addr;
	logic [ASF_DATA_W-1:0] wr_data;
	logic [3:0]            wr_strb;
	logic                  wr_err;
	logic                  rd_req;
	logic [ASF_ADDR_W-1:0] rd_addr;
	logic [ASF_DATA_W-1:0] rd_data;
	logic                  rd_err;
	logic [ASF_RES_W-1:0]  clamped;
	logic                  range_now;
	logic [7:0]            status_byte;
	logic [ASF_ADDR_W-1:0] wr_word;
	logic [ASF_ADDR_W-1:0] rd_word;

	asf_axil_slave u_bus (
		.i_mclk    (i_mclk),
		.i_rst_n   (i_rst_n),
		.i_awaddr  (i_awaddr),
		.i_awvalid (i_awvalid),
		.o_awready (o_awready),
		.i_wdata   (i_wdata),
		.i_wstrb   (i_wstrb),
		.i_wvalid  (i_wvalid),
		.o_wready  (o_wready),
		.o_bresp   (o_bresp),
		.o_bvalid  (o_bvalid),
		.i_bready  (i_bready),
		.i_araddr  (i_araddr),
		.i_arvalid (i_arvalid),
		.o_arready (o_arready),
		.o_rdata   (o_rdata),
		.o_rresp   (o_rresp),
		.o_rvalid  (o_rvalid),
		.i_rready  (i_rready),
		.o_wr_req  (wr_req),
		.o_wr_addr (wr_addr),
		.o_wr_data (wr_data),
		.o_wr_strb (wr_strb),
		.i_wr_err  (wr_err),
		.o_rd_req  (rd_req),
		.o_rd_addr (rd_addr),
		.i_rd_data (rd_data),
		.i_rd_err  (rd_err)
	);

	asf_clamp u_clamp (
		.i_raw       (i_result),
		.i_over      (i_overrange),
		.i_under     (i_underrange),
		.o_result    (clamped),
		.o_range_err (range_now)
	);

	// Status byte as seen by software; bit order matches the field constants.
	assign status_byte = {r.rdy, r.range_err, r.crc_err, r.reg_err, r.chan};

	// Low address bits are ignored so that any byte address hits its word.
	assign wr_word = {wr_addr[ASF_ADDR_W-1:2], 2'b00};
	assign rd_word = {rd_addr[ASF_ADDR_W-1:2], 2'b00};

	always_comb begin
		rd_err  = 1'b0;
		rd_data = '0;
		case (rd_word)
			ASF_OFS_STATUS: begin
				rd_data = {24'h000000, status_byte};
			end
			ASF_OFS_DATA: begin
				// The status byte is appended in the top byte, after the result bits.
				rd_data = {(r.append ? status_byte : 8'h00), r.result};
			end
			ASF_OFS_IFMODE: begin
				rd_data = {30'h0, r.check_en, r.append};
			end
			ASF_OFS_IRQ_STAT: begin
				rd_data = {28'h0000000, r.irq_stat};
			end
			ASF_OFS_IRQ_MASK: begin
				rd_data = {28'h0000000, r.irq_mask};
			end
			ASF_OFS_CHK_REF: begin
				rd_data = r.check_ref;
			end
			default: begin
				rd_err = 1'b1;
			end
		endcase
	end

	always_comb begin
		case (wr_word)
			ASF_OFS_STATUS, ASF_OFS_DATA, ASF_OFS_IFMODE, ASF_OFS_IRQ_STAT,
			ASF_OFS_IRQ_MASK, ASF_OFS_CHK_REF: begin
				wr_err = 1'b0;
			end
			default: begin
				wr_err = 1'b1;
			end
		endcase
	end

	always_comb begin
		logic                 rdy_fall;
		logic                 rng_set;
		logic                 reg_set;
		logic [ASF_IRQ_W-1:0] events;
		logic                 new_check;
		rdy_fall  = 1'b0;
		rng_set   = 1'b0;
		reg_set   = 1'b0;
		events    = '0;
		new_check = r.check_en;
		next_r    = r;

		// Software writes. Status, data and reference words are read-only.
		if (wr_req && wr_strb[0]) begin
			case (wr_word)
				ASF_OFS_IFMODE: begin
					next_r.append = wr_data[ASF_IF_APPEND];
					new_check     = wr_data[ASF_IF_CHECK];
				end
				ASF_OFS_IRQ_MASK: begin
					next_r.irq_mask = wr_data[ASF_IRQ_W-1:0];
				end
				ASF_OFS_IRQ_STAT: begin
					next_r.irq_stat = r.irq_stat & ~wr_data[ASF_IRQ_W-1:0];
				end
				default: begin
					next_r.append = r.append;
				end
			endcase
		end

		// Read side effects act after the old value has been returned.
		if (rd_req && (rd_word == ASF_OFS_DATA)) begin
			next_r.rdy = 1'b1;
		end
		if (rd_req && (rd_word == ASF_OFS_STATUS)) begin
			next_r.crc_err = 1'b0;
		end

		// Calibration results lower ready instead of conversion results.
		if (i_cal_mode) begin
			rdy_fall = i_cal_done;
		end else if (i_result_valid) begin
			rdy_fall         = 1'b1;
			next_r.result    = clamped;
			next_r.range_err = range_now;
			next_r.chan      = i_result_chan;
			rng_set          = range_now & ~r.range_err;
		end
		// A new result beats a data read in the same cycle, so it is not lost.
		if (rdy_fall) begin
			next_r.rdy = 1'b0;
		end

		// Set wins over the read clear so a failing write is never missed.
		if (i_crc_wr_fail) begin
			next_r.crc_err = 1'b1;
		end

		// The reference is the register image at the enabling write.
		if (new_check && !r.check_en) begin
			next_r.check_ref = i_reg_image;
		end
		next_r.check_en = new_check;
		if (!new_check) begin
			next_r.reg_err = 1'b0;
		end else if (r.check_en && (i_reg_image != r.check_ref)) begin
			next_r.reg_err = 1'b1;
			reg_set        = ~r.reg_err;
		end

		events[ASF_IRQ_RESULT] = rdy_fall;
		events[ASF_IRQ_RANGE]  = rng_set;
		events[ASF_IRQ_CRC]    = i_crc_wr_fail;
		events[ASF_IRQ_REG]    = reg_set;
		next_r.irq_stat = next_r.irq_stat | events;
		next_r.irq      = |(next_r.irq_stat & next_r.irq_mask);

		// The pin is released while a register read shifts out on it.
		next_r.dout_oe = ~i_cs_n & ~i_reg_read_busy;
		next_r.dout    = next_r.rdy;
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r <= ASF_REGS_RST;
		end else begin
			r <= next_r;
		end
	end

	assign o_dout_rdy    = r.dout;
	assign o_dout_rdy_oe = r.dout_oe;
	assign o_irq         = r.irq;
endmodule
`default_nettype wire

// file: shared/asf_pkg.sv
/*
 * Constants, register map and types for the converter status register block.
 * Assumes a single 10 MHz clock domain and AXI4-Lite register access.
 */
// Overview of operation
// - Eight-bit status register, resets to 0x80.
// - Append status byte to data reads when enabled.
// - Ready bit drives shared output pin when idle.
// - Ready bit clears when new result is stored.
// - In calibration, ready clears on calibration result.
// - Reading data register sets ready bit again.
// - Bit six flags over or under range.
// - Clamp result to all ones or zeros.
// - Range flag updates only on result writes.
// - Bit five sets on failing write checksum.
// - Reading status clears the write checksum flag.
// - Bit four flags register image mismatch.
// - Enabling integrity check captures the reference value.
// - Integrity flag clears only when check disabled.
// - Bits three to zero give result's channel.
// - Channel index is plain binary, 0x0 to 0xf.
package asf_pkg;
	localparam int ASF_ADDR_W = 8;
	localparam int ASF_DATA_W = 32;
	localparam int ASF_RES_W  = 24;
	localparam int ASF_CHAN_W = 4;
	localparam int ASF_IRQ_W  = 4;

	localparam logic [7:0] ASF_OFS_STATUS   = 8'h00;
	localparam logic [7:0] ASF_OFS_DATA     = 8'h04;
	localparam logic [7:0] ASF_OFS_IFMODE   = 8'h08;
	localparam logic [7:0] ASF_OFS_IRQ_STAT = 8'h0c;
	localparam logic [7:0] ASF_OFS_IRQ_MASK = 8'h10;
	localparam logic [7:0] ASF_OFS_CHK_REF  = 8'h14;

	localparam logic [7:0] ASF_STATUS_RST = 8'h80;
	localparam int ASF_BIT_RDY   = 7;
	localparam int ASF_BIT_RANGE = 6;
	localparam int ASF_BIT_CRC   = 5;
	localparam int ASF_BIT_REG   = 4;

	localparam int ASF_IF_APPEND = 0;
	localparam int ASF_IF_CHECK  = 1;

	localparam int ASF_IRQ_RESULT = 0;
	localparam int ASF_IRQ_RANGE  = 1;
	localparam int ASF_IRQ_CRC    = 2;
	localparam int ASF_IRQ_REG    = 3;

	localparam logic [23:0] ASF_RES_FULL  = 24'hffffff;
	localparam logic [23:0] ASF_RES_EMPTY = 24'h000000;

	localparam logic [1:0] ASF_RESP_OKAY   = 2'h0;
	localparam logic [1:0] ASF_RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ASF_S_IDLE = 3'h1,
		ASF_S_BUSY = 3'h2,
		ASF_S_RESP = 3'h4
	} asf_state_t;
endpackage

// file: testbench/asf_host_model.sv
/*
 * Host side of the serial port: one frame with a register read inside it.
 * Assumes the bench pulses i_go for one cycle and waits for o_done.
 */
`timescale 1ns/1ps
`default_nettype none
module asf_host_model (
	// Clock and reset
	input  wire logic i_mclk,
	input  wire logic i_rst_n,
	// Control
	input  wire logic i_go,
	output logic      o_done,
	output logic      o_rdy_seen,
	output logic      o_oe_busy,
	// Serial pins
	output logic      o_cs_n,
	output logic      o_reg_read_busy,
	input  wire logic i_dout_rdy,
	input  wire logic i_dout_rdy_oe
);
	int cnt;
	// The host samples the pin enable at count 5 and the ready level at count 9 of each frame.
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt <= 0;
			o_done <= 1'b0;
			o_rdy_seen <= 1'b0;
			o_oe_busy <= 1'b0;
		end else begin
			cnt <= (i_go || (cnt > 0 && cnt < 11)) ? cnt + 1 : 0;
			o_done <= (cnt == 11);
			if (cnt == 5) o_oe_busy <= i_dout_rdy_oe;
			if (cnt == 9) o_rdy_seen <= i_dout_rdy & i_dout_rdy_oe;
		end
	end
	assign o_cs_n = !(cnt >= 1 && cnt <= 10);
	assign o_reg_read_busy = (cnt >= 2 && cnt <= 5);
endmodule
`default_nettype wire

// file: testbench/asf_status_properties.sv
/*
 * Concurrent checks for the converter status block, bound to its top module.
 * Assumes one clock domain and a bench that offers write address and data together.
 */
`timescale 1ns/1ps
`default_nettype none
module asf_status_properties (
	// Clock and reset
	input wire logic                           i_mclk,
	input wire logic                           i_rst_n,
	// Register bus
	input wire logic [asf_pkg::ASF_ADDR_W-1:0] i_awaddr,
	input wire logic                           i_awvalid,
	input wire logic                           o_awready,
	input wire logic                           i_wvalid,
	input wire logic                           o_wready,
	input wire logic [1:0]                     o_bresp,
	input wire logic                           o_bvalid,
	input wire logic [asf_pkg::ASF_ADDR_W-1:0] i_araddr,
	input wire logic                           i_arvalid,
	input wire logic                           o_arready,
	input wire logic [asf_pkg::ASF_DATA_W-1:0] o_rdata,
	input wire logic [1:0]                     o_rresp,
	input wire logic                           o_rvalid,
	input wire logic                           i_rready,
	// Converter and pin
	input wire logic                           i_result_valid,
	input wire logic                           i_cal_mode,
	input wire logic                           i_cal_done,
	input wire logic                           i_cs_n,
	input wire logic                           i_reg_read_busy,
	input wire logic                           o_dout_rdy,
	input wire logic                           o_dout_rdy_oe
);
	import asf_pkg::*;
	logic [ASF_ADDR_W-1:0] aw_q;
	logic [ASF_ADDR_W-1:0] ar_q;
	// Addresses are kept so that each response can be tied to its own request.
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			aw_q <= '0;
			ar_q <= '0;
		end else begin
			if (i_awvalid && o_awready) aw_q <= i_awaddr;
			if (i_arvalid && o_arready) ar_q <= i_araddr;
		end
	end
	function automatic logic [1:0] exp_resp(input logic [7:0] a);
		return (a > ASF_OFS_CHK_REF) ? ASF_RESP_SLVERR : ASF_RESP_OKAY;
	endfunction
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	AST_RDY_PIN: assert property ($past(i_rst_n) |->
		o_dout_rdy_oe == $past(!i_cs_n && !i_reg_read_busy)) else $error("Pin enable wrong.");
	AST_RDY_CLR: assert property (i_result_valid && !i_cal_mode |=> !o_dout_rdy)
		else $error("Ready did not fall on result.");
	AST_CAL_CLR: assert property (i_cal_mode && i_cal_done |=> !o_dout_rdy)
		else $error("Ready did not fall on calibration.");
	AST_RDY_HOLD: assert property (o_dout_rdy && !(i_result_valid && !i_cal_mode)
		&& !(i_cal_mode && i_cal_done) |=> o_dout_rdy) else $error("Ready fell early.");
	AST_W_LAT: assert property (i_awvalid && o_awready && i_wvalid && o_wready
		|-> ##2 o_bvalid) else $error("Write response late.");
	AST_R_LAT: assert property (i_arvalid && o_arready |-> ##[2:3] o_rvalid)
		else $error("Read response late.");
	AST_W_RESP: assert property ($rose(o_bvalid) |-> o_bresp == exp_resp(aw_q))
		else $error("Write response code wrong.");
	AST_R_RESP: assert property ($rose(o_rvalid) |-> o_rresp == exp_resp(ar_q))
		else $error("Read response code wrong.");
	AST_R_HOLD: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
		else $error("Read data not held.");
	cover property (i_result_valid && !i_cal_mode);
	cover property (i_cal_mode && i_cal_done);
	cover property ($rose(o_bvalid) && o_bresp == ASF_RESP_SLVERR);
endmodule
bind asf_status_top asf_status_properties u_props (.i_mclk, .i_rst_n, .i_awaddr, .i_awvalid,
	.o_awready, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_araddr, .i_arvalid, .o_arready,
	.o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_result_valid, .i_cal_mode, .i_cal_done,
	.i_cs_n, .i_reg_read_busy, .o_dout_rdy, .o_dout_rdy_oe);
`default_nettype wire

// file: testbench/asf_status_tb_top.sv
/*
 * Self-checking bench for the converter status block with a reference model.
 * Assumes the bound checker and the host model are compiled alongside.
 */
`timescale 1ns/1ps
`default_nettype none
module asf_status_tb_top;
	import asf_pkg::*;
	logic i_mclk, i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq, go, hdone, seen, obusy;
	logic i_result_valid, i_overrange, i_underrange, i_cal_mode, i_cal_done, i_crc_wr_fail;
	logic i_cs_n, i_reg_read_busy, o_dout_rdy, o_dout_rdy_oe;
	logic [7:0] i_awaddr, i_araddr;
	logic [31:0] i_wdata, o_rdata, i_reg_image, img, d;
	logic [3:0] i_wstrb, i_result_chan;
	logic [1:0] o_bresp, o_rresp;
	logic [23:0] i_result, m_res;
	logic m_rdy, m_rng, m_crc, m_reg, m_app, m_cal;
	logic [3:0] m_ch;
	int fails, samples_checked, cyc = 0;
	asf_status_top u_dut (.i_mclk, .i_rst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
		.i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
		.o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_result_valid, .i_result,
		.i_overrange, .i_underrange, .i_result_chan, .i_cal_mode, .i_cal_done, .i_crc_wr_fail,
		.i_reg_image, .i_cs_n, .i_reg_read_busy, .o_dout_rdy, .o_dout_rdy_oe, .o_irq);
	asf_host_model u_host (.i_mclk, .i_rst_n, .i_go(go), .o_done(hdone), .o_rdy_seen(seen),
		.o_oe_busy(obusy), .o_cs_n(i_cs_n), .o_reg_read_busy(i_reg_read_busy), .i_dout_rdy(o_dout_rdy),
		.i_dout_rdy_oe(o_dout_rdy_oe));
	initial begin
		i_mclk = 1'b0;
		forever #50 i_mclk = ~i_mclk;
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// The ceiling is more than fifty times the expected run of under 400 cycles, so only a real hang reaches it.
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			summarize();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [7:0] mst();
		return {m_rdy, m_rng, m_crc, m_reg, m_ch};
	endfunction
	task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		@(posedge i_mclk);
		i_awaddr <= a;
		i_wdata <= v;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		do begin
			@(posedge i_mclk);
			if (o_awready) i_awvalid <= 1'b0;
			if (o_wready) i_wvalid <= 1'b0;
		end while (!o_bvalid);
		chk(o_bresp, er);
		i_bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a, input logic [1:0] er);
		@(posedge i_mclk);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		do begin
			@(posedge i_mclk);
			if (o_arready) i_arvalid <= 1'b0;
		end while (!o_rvalid);
		d = o_rdata;
		chk(o_rresp, er);
		i_rready <= 1'b0;
	endtask
	task automatic rd_stat();
		axr(ASF_OFS_STATUS, ASF_RESP_OKAY);
		chk(d, {24'h0, mst()});
		m_crc = 1'b0;
	endtask
	task automatic rd_data();
		axr(ASF_OFS_DATA, ASF_RESP_OKAY);
		chk(d, {m_app ? mst() : 8'h00, m_res});
		m_rdy = 1'b1;
	endtask
	task automatic res(input logic [23:0] raw, input logic ov, input logic un, input logic [3:0] c);
		@(posedge i_mclk);
		i_result <= raw;
		i_overrange <= ov;
		i_underrange <= un;
		i_result_chan <= c;
		i_result_valid <= 1'b1;
		@(posedge i_mclk);
		i_result_valid <= 1'b0;
		if (!m_cal) begin
			m_rdy = 1'b0;
			m_rng = ov | un;
			m_res = ov ? ASF_RES_FULL : (un ? ASF_RES_EMPTY : raw);
			m_ch = c;
		end
	endtask
	task automatic frame();
		@(posedge i_mclk);
		go <= 1'b1;
		@(posedge i_mclk);
		go <= 1'b0;
		do @(posedge i_mclk); while (!hdone);
		chk(seen, m_rdy);
		chk(obusy, 1'b0);
	endtask
	task automatic pulse(input logic cal);
		@(posedge i_mclk);
		if (cal) i_cal_done <= 1'b1;
		else i_crc_wr_fail <= 1'b1;
		@(posedge i_mclk);
		{i_cal_done, i_crc_wr_fail} <= 2'b00;
		repeat (2) @(posedge i_mclk);
	endtask
	initial begin
		{i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, go} = '0;
		{i_result_valid, i_overrange, i_underrange, i_cal_mode, i_cal_done, i_crc_wr_fail} = '0;
		{i_awaddr, i_araddr, i_wdata, i_result, i_result_chan, fails, samples_checked} = '0;
		{m_rng, m_crc, m_reg, m_app, m_cal, m_ch, m_res} = '0;
		i_wstrb = 4'hf;
		m_rdy = 1'b1;
		void'($urandom(11));
		img = $urandom;
		i_reg_image <= img;
		repeat (12) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		rd_stat();
		axw(ASF_OFS_STATUS, 32'hff, ASF_RESP_OKAY);
		rd_stat();
		axr(8'h40, ASF_RESP_SLVERR);
		axw(8'h40, 32'h1, ASF_RESP_SLVERR);
		axr(ASF_OFS_IRQ_MASK, ASF_RESP_OKAY);
		chk(d, 32'h0);
		for (int c = 0; c < 16; c++) begin
			if (c == 8) axw(ASF_OFS_IFMODE, 32'h1, ASF_RESP_OKAY);
			if (c == 8) m_app = 1'b1;
			res(24'($urandom), c % 4 == 1, c % 4 == 2, c[3:0]);
			if (c < 2) frame();
			rd_stat();
			rd_data();
			if (c < 2) frame();
		end
		pulse(1'b0);
		m_crc = 1'b1;
		chk(o_irq, 1'b0);
		axw(ASF_OFS_IRQ_MASK, 32'h4, ASF_RESP_OKAY);
		repeat (2) @(posedge i_mclk);
		chk(o_irq, 1'b1);
		rd_stat();
		rd_stat();
		axw(ASF_OFS_IRQ_STAT, 32'h4, ASF_RESP_OKAY);
		repeat (2) @(posedge i_mclk);
		chk(o_irq, 1'b0);
		i_cal_mode <= 1'b1;
		m_cal = 1'b1;
		res(24'($urandom), 1'b1, 1'b0, 4'h3);
		rd_stat();
		pulse(1'b1);
		m_rdy = 1'b0;
		rd_stat();
		i_cal_mode <= 1'b0;
		m_cal = 1'b0;
		rd_data();
		axw(ASF_OFS_IFMODE, 32'h3, ASF_RESP_OKAY);
		axr(ASF_OFS_CHK_REF, ASF_RESP_OKAY);
		chk(d, img);
		i_reg_image <= ~img;
		repeat (2) @(posedge i_mclk);
		m_reg = 1'b1;
		rd_stat();
		i_reg_image <= img;
		rd_stat();
		axw(ASF_OFS_IFMODE, 32'h1, ASF_RESP_OKAY);
		m_reg = 1'b0;
		rd_stat();
		summarize();
	end
endmodule
`default_nettype wire
